// ===== verilog/srif_pkg.sv
// Package for the serial port register interface: offsets, field positions, reset values.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package srif_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [11:0] OFS_IEN_BITS = 12'h044;
    localparam logic [11:0] OFS_RAW_FLAGS = 12'h048;
    localparam logic [11:0] OFS_MASKED_FLAGS = 12'h04C;
    localparam logic [11:0] OFS_IEN_SET = 12'h058;
    localparam logic [11:0] OFS_IEN_CLEAR = 12'h05C;
    localparam logic [11:0] OFS_HALT_CTRL = 12'h060;
    localparam logic [11:0] OFS_FRAME_CFG = 12'h100;
    localparam logic [11:0] OFS_ROLE_CFG = 12'h104;
    localparam logic [11:0] OFS_PRESCALE = 12'h108;
    localparam logic [11:0] OFS_RATE_DELAY = 12'h10C;
    localparam logic [11:0] OFS_THRESH = 12'h110;
    localparam logic [11:0] OFS_XFER_REQ = 12'h114;
    localparam logic [11:0] OFS_RX_CHECK = 12'h118;
    localparam logic [11:0] OFS_TX_CHECK = 12'h11C;
    localparam logic [11:0] OFS_HDR32 = 12'h120;
    localparam logic [11:0] OFS_HDR24 = 12'h124;
    localparam logic [11:0] OFS_HDR16 = 12'h128;
    localparam logic [11:0] OFS_HDR8 = 12'h12C;
    localparam logic [11:0] OFS_HDR_CTRL = 12'h130;
    localparam logic [11:0] OFS_RX_PORT = 12'h140;
    localparam logic [11:0] OFS_TX_PORT = 12'h150;
    localparam logic [11:0] OFS_LINE_FLAGS = 12'h160;
    // ----------------------------------------
    // Reset values and fields
    // ----------------------------------------
    localparam logic [31:0] RST_ROLE_CFG = 32'h0000_0004;
    localparam logic [31:0] RST_THRESH = 32'h0000_0202;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam int POLY_BIT = 14;
    localparam int RATE_LSB = 0;
    localparam int RATE_W = 10;
    localparam int DELAY_LSB = 16;
    localparam int DELAY_W = 4;
    localparam int TRANSMIT_LEVEL_CHOICE_LSB = 0;
    localparam int RECEIVE_LEVEL_CHOICE_LSB = 8;
    localparam int SEL_W = 3;
    localparam int FLAG_RX = 0;
    localparam int FLAG_TX = 1;
    localparam int FLAG_W = 2;
    localparam int HALT_FREE_BIT = 0;
    localparam int ROLE_CTRL_BIT = 2;
    localparam logic [7:0] SEED8 = 8'hFF;
    localparam logic [15:0] SEED16 = 16'hFFFF;
    localparam logic [7:0] POLY8 = 8'h07;
    localparam logic [15:0] POLY16 = 16'h1021;
    // Threshold choice encodings
    localparam logic [2:0] SEL_Q1 = 3'h1;
    localparam logic [2:0] SEL_HALF = 3'h2;
    localparam logic [2:0] SEL_Q3 = 3'h3;
    localparam logic [2:0] SEL_EDGE = 3'h4;
endpackage

// ===== verilog/srif_regs.sv
// Register interface of a synchronous serial port: Wishbone slave, FIFOs, checksum units.
// Assumes the serial engine pushes receive bytes and pops transmit bytes, and a halt input.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns

module srif_regs
    import srif_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial engine side
    input wire logic core_halted_i,
    input wire logic eng_word_end_i,
    input wire logic rx_push_i,
    input wire logic [7:0] rx_data_i,
    input wire logic tx_pop_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    output logic rx_ready_o,
    output logic eng_freeze_o,
    output logic [RATE_W-1:0] rate_div_o,
    output logic [DELAY_W-1:0] sample_delay_o,
    output logic [FLAG_W-1:0] masked_flags_o
);
    if (DEPTH != (1 << AW) || AW < 2) begin : g_bad_depth
        $error("DEPTH must equal 2**AW with AW of at least 2");
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic req;
    logic wr;
    logic rd;
    logic [31:0] wmask;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    logic [31:0] ien_q;
    logic [31:0] halt_ctrl_q;
    logic [31:0] frame_q;
    logic [31:0] role_q;
    logic [31:0] presc_q;
    logic [31:0] rate_q;
    logic [31:0] thresh_q;
    logic [31:0] xfer_q;
    logic [31:0] hdrc_q;
    logic [31:0] txlast_q;
    logic [31:0] rxlast_q;
    logic [31:0] raw;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ien_q <= ZERO32;
        end else if (wr && wb_adr_i == OFS_IEN_CLEAR) begin
            ien_q <= ien_q & ~(wb_dat_i & wmask);
        end else if (wr && wb_adr_i == OFS_IEN_SET) begin
            ien_q <= ien_q | (wb_dat_i & wmask);
        end else if (wr && wb_adr_i == OFS_IEN_BITS) begin
            ien_q <= merge(ien_q, wb_dat_i, wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_ctrl_q <= ZERO32;
            frame_q <= ZERO32;
            role_q <= RST_ROLE_CFG;
            presc_q <= ZERO32;
            rate_q <= ZERO32;
            thresh_q <= RST_THRESH;
            xfer_q <= ZERO32;
            hdrc_q <= ZERO32;
        end else if (wr) begin
            if (wb_adr_i == OFS_HALT_CTRL) begin
                halt_ctrl_q <= merge(halt_ctrl_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_FRAME_CFG) begin
                frame_q <= merge(frame_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_ROLE_CFG) begin
                role_q <= merge(role_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_PRESCALE) begin
                presc_q <= merge(presc_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_RATE_DELAY) begin
                rate_q <= merge(rate_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_THRESH) begin
                thresh_q <= merge(thresh_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_XFER_REQ) begin
                xfer_q <= merge(xfer_q, wb_dat_i, wmask);
            end else if (wb_adr_i == OFS_HDR_CTRL) begin
                hdrc_q <= merge(hdrc_q, wb_dat_i, wmask);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_div_o <= '0;
            sample_delay_o <= '0;
        end else begin
            rate_div_o <= rate_q[RATE_LSB +: RATE_W];
            sample_delay_o <= rate_q[DELAY_LSB +: DELAY_W];
        end
    end

    // ----------------------------------------
    // Halt freeze
    // ----------------------------------------
    // Controller waits for the word boundary so no partial word leaves the pins.
    logic halt_act;
    assign halt_act = core_halted_i && !halt_ctrl_q[HALT_FREE_BIT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng_freeze_o <= 1'b0;
        end else if (!halt_act) begin
            eng_freeze_o <= 1'b0;
        end else if (!role_q[ROLE_CTRL_BIT] || eng_word_end_i) begin
            eng_freeze_o <= 1'b1;
        end
    end

    // ----------------------------------------
    // Transmit FIFO, bytes
    // ----------------------------------------
    logic [7:0] txm [DEPTH];
    logic [AW:0] tx_wp_q;
    logic [AW:0] tx_rp_q;
    logic [AW:0] tx_cnt;
    logic [2:0] push_n;
    logic [31:0] push_w;
    assign tx_cnt = tx_wp_q - tx_rp_q;

    always_comb begin
        push_n = 3'h0;
        push_w = wb_dat_i;
        if (wr && wb_adr_i == OFS_TX_PORT) begin
            push_n = 3'h1;
        end else if (wr && wb_adr_i == OFS_HDR32) begin
            push_n = 3'h4;
        end else if (wr && wb_adr_i == OFS_HDR24) begin
            push_n = 3'h3;
        end else if (wr && wb_adr_i == OFS_HDR16) begin
            push_n = 3'h2;
        end else if (wr && wb_adr_i == OFS_HDR8) begin
            push_n = 3'h1;
        end
        if (32'(push_n) > DEPTH - 32'(tx_cnt)) begin
            push_n = 3'h0;
        end
    end

    // Header bytes go out most significant first.
    genvar g;
    for (g = 0; g < DEPTH; g++) begin : g_push
        logic [AW-1:0] slot;
        assign slot = AW'(g) - tx_wp_q[AW-1:0];
        always_ff @(posedge clk_i) begin
            if (32'(slot) < 32'(push_n)) begin
                txm[g] <= push_w[8*(32'(push_n) - 1 - 32'(slot)) +: 8];
            end
        end
    end

    logic tx_pop;
    assign tx_pop = tx_pop_i && tx_cnt != '0 && !eng_freeze_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
        end else begin
            tx_wp_q <= tx_wp_q + (AW+1)'(push_n);
            if (tx_pop) begin
                tx_rp_q <= tx_rp_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_o <= 8'h00;
            tx_valid_o <= 1'b0;
            txlast_q <= ZERO32;
        end else begin
            tx_data_o <= txm[tx_rp_q[AW-1:0]];
            tx_valid_o <= tx_cnt != '0 && !tx_pop;
            if (wr && wb_adr_i == OFS_TX_PORT) begin
                txlast_q <= merge(txlast_q, wb_dat_i, wmask);
            end
        end
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    logic [7:0] rxm [DEPTH];
    logic [AW:0] rx_wp_q;
    logic [AW:0] rx_rp_q;
    logic [AW:0] rx_cnt;
    logic rx_pop;
    logic rx_push;
    assign rx_cnt = rx_wp_q - rx_rp_q;
    // Writes to the receive port fall through every decode below.
    assign rx_pop = rd && wb_adr_i == OFS_RX_PORT && rx_cnt != '0 && !core_halted_i;
    assign rx_push = rx_push_i && rx_cnt != (AW+1)'(DEPTH) && !eng_freeze_o;

    always_ff @(posedge clk_i) begin
        if (rx_push) begin
            rxm[rx_wp_q[AW-1:0]] <= rx_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rxlast_q <= ZERO32;
            rx_ready_o <= 1'b0;
        end else begin
            rx_ready_o <= rx_cnt + (AW+1)'(rx_push) < (AW+1)'(DEPTH);
            if (rx_push) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + 1'b1;
                rxlast_q <= {24'h0, rxm[rx_rp_q[AW-1:0]]};
            end
        end
    end

    // ----------------------------------------
    // Threshold flags
    // ----------------------------------------
    function automatic logic level_hit(input logic [2:0] sel, input logic [AW:0] n);
        logic [AW+2:0] n4;
        logic [AW+2:0] d;
        n4 = {n, 2'b00};
        d = (AW+3)'(DEPTH);
        case (sel)
            SEL_Q1: level_hit = n4 >= d;
            SEL_HALF: level_hit = n4 >= 2 * d;
            SEL_Q3: level_hit = n4 >= 3 * d;
            SEL_EDGE: level_hit = n4 >= 4 * d;
            default: level_hit = n != '0;
        endcase
    endfunction

    logic [AW:0] tx_free;
    assign tx_free = (AW+1)'(DEPTH) - tx_cnt;
    always_comb begin
        raw = ZERO32;
        raw[FLAG_RX] = level_hit(thresh_q[RECEIVE_LEVEL_CHOICE_LSB +: SEL_W], rx_cnt);
        raw[FLAG_TX] = level_hit(thresh_q[TRANSMIT_LEVEL_CHOICE_LSB +: SEL_W], tx_free);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            masked_flags_o <= '0;
        end else begin
            masked_flags_o <= raw[FLAG_W-1:0] & ien_q[FLAG_W-1:0];
        end
    end

    // ----------------------------------------
    // Checksum units
    // ----------------------------------------
    logic poly16;
    logic [15:0] rx_crc_q;
    logic [15:0] tx_crc_q;
    logic [15:0] seed;
    assign poly16 = frame_q[POLY_BIT];
    assign seed = poly16 ? SEED16 : {8'h00, SEED8};

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b,
                                             input logic w16);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            if (w16) begin
                r = (r[15] ^ b[i]) ? ((r << 1) ^ POLY16) : (r << 1);
            end else begin
                r[7:0] = (r[7] ^ b[i]) ? ((r[7:0] << 1) ^ POLY8) : (r[7:0] << 1);
            end
        end
        crc_step = r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_crc_q <= 16'h0000;
            tx_crc_q <= 16'h0000;
        end else begin
            if (req && wb_adr_i == OFS_RX_CHECK) begin
                rx_crc_q <= seed;
            end else if (rx_push) begin
                rx_crc_q <= crc_step(rx_crc_q, rx_data_i, poly16);
            end
            if (req && wb_adr_i == OFS_TX_CHECK) begin
                tx_crc_q <= seed;
            end else if (tx_pop) begin
                tx_crc_q <= crc_step(tx_crc_q, txm[tx_rp_q[AW-1:0]], poly16);
            end
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    logic [31:0] rdata;
    always_comb begin
        if (wb_adr_i == OFS_IEN_BITS) begin
            rdata = ien_q;
        end else if (wb_adr_i == OFS_RAW_FLAGS) begin
            rdata = raw;
        end else if (wb_adr_i == OFS_MASKED_FLAGS) begin
            rdata = raw & ien_q;
        end else if (wb_adr_i == OFS_HALT_CTRL) begin
            rdata = halt_ctrl_q;
        end else if (wb_adr_i == OFS_FRAME_CFG) begin
            rdata = frame_q;
        end else if (wb_adr_i == OFS_ROLE_CFG) begin
            rdata = role_q;
        end else if (wb_adr_i == OFS_PRESCALE) begin
            rdata = presc_q;
        end else if (wb_adr_i == OFS_RATE_DELAY) begin
            rdata = rate_q;
        end else if (wb_adr_i == OFS_THRESH) begin
            rdata = thresh_q;
        end else if (wb_adr_i == OFS_XFER_REQ) begin
            rdata = xfer_q;
        end else if (wb_adr_i == OFS_RX_CHECK) begin
            rdata = {16'h0000, rx_crc_q};
        end else if (wb_adr_i == OFS_TX_CHECK) begin
            rdata = {16'h0000, tx_crc_q};
        end else if (wb_adr_i == OFS_HDR_CTRL) begin
            rdata = hdrc_q;
        end else if (wb_adr_i == OFS_RX_PORT) begin
            rdata = rx_pop ? {24'h0, rxm[rx_rp_q[AW-1:0]]} : rxlast_q;
        end else if (wb_adr_i == OFS_TX_PORT) begin
            rdata = txlast_q;
        end else if (wb_adr_i == OFS_LINE_FLAGS) begin
            rdata = {28'h0, rx_cnt != (AW+1)'(DEPTH), rx_cnt == '0,
                     tx_cnt != (AW+1)'(DEPTH), tx_cnt == '0};
        end else begin
            rdata = ZERO32;
        end
    end

    // Every access, mapped or not, is acknowledged one cycle after it is seen.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= ZERO32;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? rdata : ZERO32;
        end
    end
endmodule

// ===== testbench/srif_regs_monitor.sv
// Checker for the serial port register interface; sees only the top-level ports.
// Assumes a classic Wishbone master with one request open at a time.
`timescale 1ns/1ns
module srif_regs_monitor
    import srif_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Engine side
    input wire logic core_halted_i,
    input wire logic eng_freeze_o,
    input wire logic [RATE_W-1:0] rate_div_o,
    input wire logic [DELAY_W-1:0] sample_delay_o,
    input wire logic [FLAG_W-1:0] masked_flags_o
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not given one cycle after request");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == ZERO32)
        else $error("read data not zero outside ack");
    mask_clear_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
        wb_adr_i == OFS_IEN_CLEAR && wb_sel_i[0] && wb_dat_i[1:0] == 2'h3
        |-> ##3 masked_flags_o == 2'h0) else $error("masked flags survive enable clear");
    rate_copy_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
        wb_adr_i == OFS_RATE_DELAY && wb_sel_i == 4'hF
        |-> ##2 rate_div_o == $past(wb_dat_i[RATE_W-1:0], 2)
        && sample_delay_o == $past(wb_dat_i[DELAY_LSB+:DELAY_W], 2))
        else $error("rate outputs do not follow write");
    halt_release_a: assert property (!core_halted_i |=> !eng_freeze_o)
        else $error("freeze held without halt");
    csum_width_a: assert property (wb_ack_o && !$past(wb_we_i) &&
        ($past(wb_adr_i) == OFS_RX_CHECK || $past(wb_adr_i) == OFS_TX_CHECK)
        |-> wb_dat_o[31:16] == 16'h0000) else $error("checksum wider than sixteen bits");
endmodule

bind srif_regs srif_regs_monitor #(.DEPTH(DEPTH), .AW(AW)) srif_regs_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_halted_i(core_halted_i),
    .eng_freeze_o(eng_freeze_o), .rate_div_o(rate_div_o),
    .sample_delay_o(sample_delay_o), .masked_flags_o(masked_flags_o));

// ===== testbench/srif_engine_model.sv
// Behavioural serial engine: pushes received bytes and pops transmit bytes.
// Assumes the bench calls its tasks and steers popping through pop_en_i.
`timescale 1ns/1ns
module srif_engine_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Transmit side
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic pop_en_i,
    output logic tx_pop_o,
    // Receive side and word boundary
    output logic rx_push_o,
    output logic [7:0] rx_data_o,
    output logic word_end_o
);
    logic [7:0] got[$];
    initial begin
        rx_push_o = 1'h0;
        rx_data_o = 8'h00;
        word_end_o = 1'h0;
    end
    // One pop at a time, so a stale head byte is never taken twice
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_pop_o <= 1'h0;
        end else begin
            if (tx_pop_o && tx_valid_i) begin
                got.push_back(tx_data_i);
            end
            tx_pop_o <= pop_en_i && tx_valid_i && !tx_pop_o;
        end
    end
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_i);
        rx_push_o <= 1'h1;
        rx_data_o <= b;
        @(posedge clk_i);
        rx_push_o <= 1'h0;
        // Released data line shows the inverse, not a held value
        rx_data_o <= ~b;
    endtask
    task automatic word_end();
        @(posedge clk_i);
        word_end_o <= 1'h1;
        @(posedge clk_i);
        word_end_o <= 1'h0;
    endtask
endmodule

// ===== testbench/srif_regs_tb.sv
// Self-checking bench for the serial port register interface.
// Assumes the engine model answers on the serial side; seed is fixed.
`timescale 1ns/1ns
module srif_regs_tb
    import srif_pkg::*;
;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, core_halted_i, pop_en;
    logic eng_word_end_i, rx_push_i, tx_pop_i, tx_valid_o, eng_freeze_o, rx_ready_o;
    logic [11:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, v, w, r;
    logic [7:0] rx_data_i, tx_data_o, b;
    logic [7:0] rb[4];
    logic [7:0] exp_q[$];
    logic [RATE_W-1:0] rate_div_o;
    logic [DELAY_W-1:0] sample_delay_o;
    logic [FLAG_W-1:0] masked_flags_o;
    int num_errors, comparisons, seed, i, j;
    logic [11:0] rst_adr[10] = '{OFS_IEN_BITS, OFS_HALT_CTRL, OFS_FRAME_CFG, OFS_ROLE_CFG,
        OFS_PRESCALE, OFS_RATE_DELAY, OFS_THRESH, OFS_XFER_REQ, 12'h200, OFS_LINE_FLAGS};
    logic [31:0] rst_val[10] = '{ZERO32, ZERO32, ZERO32, RST_ROLE_CFG, ZERO32, ZERO32,
        RST_THRESH, ZERO32, ZERO32, 32'h0000000F};
    logic [11:0] hadr[4] = '{OFS_HDR32, OFS_HDR24, OFS_HDR16, OFS_HDR8};
    srif_regs srif_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .core_halted_i(core_halted_i), .eng_word_end_i(eng_word_end_i),
        .rx_push_i(rx_push_i), .rx_data_i(rx_data_i), .tx_pop_i(tx_pop_i),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .rx_ready_o(rx_ready_o),
        .eng_freeze_o(eng_freeze_o), .rate_div_o(rate_div_o),
        .sample_delay_o(sample_delay_o), .masked_flags_o(masked_flags_o));
    srif_engine_model srif_engine_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o), .pop_en_i(pop_en),
        .tx_pop_o(tx_pop_i), .rx_push_o(rx_push_i), .rx_data_o(rx_data_i),
        .word_end_o(eng_word_end_i));
    always #5 clk_i = ~clk_i;
    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        r = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        wb(1'h0, a, $random(seed));
        chk($sformatf("read %h", a), e & m, r & m);
    endtask
    task automatic flags(input logic [1:0] e);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("masked flags", {30'h0, e}, {30'h0, masked_flags_o});
    endtask
    task automatic freeze(input logic e);
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        chk("freeze", {31'h0, e}, {31'h0, eng_freeze_o});
    endtask
    // Far side stalls at random while the FIFO drains
    task automatic drain();
        int n;
        for (n = 0; n < 200 && srif_engine_model_i.got.size() < exp_q.size(); n++) begin
            @(posedge clk_i);
            pop_en <= $random(seed);
        end
        pop_en <= 1'h1;
        repeat (6) @(posedge clk_i);
        pop_en <= 1'h0;
        chk("tx count", exp_q.size(), srif_engine_model_i.got.size());
        while (exp_q.size() > 0 && srif_engine_model_i.got.size() > 0) begin
            chk("tx byte", exp_q.pop_front(), srif_engine_model_i.got.pop_front());
        end
        exp_q.delete();
        srif_engine_model_i.got.delete();
        if (n >= 200) begin
            num_errors++;
            complete_run();
        end
    endtask
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {d, 8'h00};
        for (int k = 0; k < 8; k++) begin
            c = c[15] ? ((c << 1) ^ POLY16) : (c << 1);
        end
        return c;
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 71009;
        {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, core_halted_i, pop_en} = 6'h00;
        {wb_adr_i, wb_dat_i} = 44'h0;
        wb_sel_i = 4'hF;
        rst_i = 1'h1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(1'h1, 12'h200, $random(seed));
        for (i = 0; i < 10; i++) rdchk(rst_adr[i], rst_val[i], 32'hFFFFFFFF);
        v = $random(seed);
        wb(1'h1, OFS_RATE_DELAY, v);
        @(negedge clk_i);
        chk("rate", {22'h0, v[RATE_W-1:0]}, {22'h0, rate_div_o});
        chk("delay", {28'h0, v[19:16]}, {28'h0, sample_delay_o});
        for (i = 0; i < 4; i++) begin
            rb[i] = $random(seed);
            srif_engine_model_i.send_byte(rb[i]);
        end
        @(negedge clk_i);
        chk("rx ready", 32'h0, {31'h0, rx_ready_o});
        wb(1'h1, OFS_IEN_SET, 32'h3);
        flags(2'h3);
        wb(1'h1, OFS_IEN_CLEAR, 32'h1);
        flags(2'h2);
        wb(1'h1, OFS_IEN_CLEAR, 32'h3);
        flags(2'h0);
        for (i = 0; i < 4; i++) rdchk(OFS_RX_PORT, {24'h0, rb[i]}, 32'hFF);
        rdchk(OFS_RX_PORT, {24'h0, rb[3]}, 32'hFF);
        wb(1'h1, OFS_RX_PORT, ~rb[3]);
        rdchk(OFS_RX_PORT, {24'h0, rb[3]}, 32'hFF);
        rdchk(OFS_LINE_FLAGS, 32'hC, 32'hC);
        chk("rx ready", 32'h1, {31'h0, rx_ready_o});
        v = $random(seed);
        wb(1'h1, OFS_TX_PORT, v);
        rdchk(OFS_TX_PORT, v, 32'hFFFFFFFF);
        exp_q.push_back(v[7:0]);
        drain();
        for (i = 0; i < 4; i++) begin
            w = $random(seed);
            wb(1'h1, hadr[i], w);
            wb(1'h1, OFS_HDR32, ~w);
            if (i == 0) rdchk(OFS_RAW_FLAGS, ZERO32, 32'h3);
            for (j = 3 - i; j >= 0; j--) exp_q.push_back(w[8*j+:8]);
            drain();
        end
        wb(1'h1, OFS_FRAME_CFG, 32'h1 << POLY_BIT);
        wb(1'h0, OFS_RX_CHECK, 32'h0);
        b = $random(seed);
        srif_engine_model_i.send_byte(b);
        rdchk(OFS_RX_CHECK, {16'h0, crc16(SEED16, b)}, 32'hFFFF);
        rdchk(OFS_RX_CHECK, {16'h0, SEED16}, 32'hFFFF);
        rdchk(OFS_RX_PORT, {24'h0, b}, 32'hFF);
        wb(1'h0, OFS_TX_CHECK, 32'h0);
        wb(1'h1, OFS_TX_PORT, {24'h0, b});
        exp_q.push_back(b);
        drain();
        rdchk(OFS_TX_CHECK, {16'h0, crc16(SEED16, b)}, 32'hFFFF);
        wb(1'h1, OFS_TX_CHECK, $random(seed));
        rdchk(OFS_TX_CHECK, {16'h0, SEED16}, 32'hFFFF);
        wb(1'h1, OFS_FRAME_CFG, ZERO32);
        wb(1'h0, OFS_RX_CHECK, 32'h0);
        rdchk(OFS_RX_CHECK, {24'h0, SEED8}, 32'hFF);
        b = $random(seed);
        srif_engine_model_i.send_byte(b);
        wb(1'h1, OFS_HALT_CTRL, 32'h1);
        core_halted_i <= 1'h1;
        srif_engine_model_i.word_end();
        freeze(1'h0);
        wb(1'h1, OFS_HALT_CTRL, ZERO32);
        freeze(1'h0);
        srif_engine_model_i.word_end();
        freeze(1'h1);
        wb(1'h0, OFS_RX_PORT, 32'h0);
        core_halted_i <= 1'h0;
        freeze(1'h0);
        rdchk(OFS_RX_PORT, {24'h0, b}, 32'hFF);
        wb(1'h1, OFS_ROLE_CFG, ZERO32);
        core_halted_i <= 1'h1;
        freeze(1'h1);
        core_halted_i <= 1'h0;
        freeze(1'h0);
        complete_run();
    end
endmodule
